// *** rtl/ccs_pkg.sv ***
package ccs_pkg;
    // oscillator and derived rates
    localparam int unsigned OSC_HZ = 14745600;
    localparam int unsigned CPU_DIV = 3;
    localparam int unsigned CPU_HZ = OSC_HZ / CPU_DIV;
    localparam int unsigned TICK_HZ = 1200;
    localparam int unsigned TICK_DIV = CPU_HZ / TICK_HZ;
    localparam int unsigned TICK_W = 12;
    // reference clock of this block
    localparam int unsigned REF_HZ = 10000000;
    // monitor and panel sizes
    localparam int unsigned MON_W = 8;
    localparam int unsigned BTN_N = 16;
    localparam int unsigned BTN_IDX_W = 4;
    localparam int unsigned DIG_N = 12;
    localparam int unsigned DIG_IDX_W = 4;
    localparam int unsigned SEG_W = 7;
    // debounce time and scan dwell
    localparam int unsigned DEB_US = 10;
    localparam int unsigned DEB_CYC = (DEB_US * (REF_HZ / 1000000));
    localparam int unsigned DEB_W = 8;
    localparam int unsigned SCAN_US = 100;
    localparam int unsigned SCAN_CYC = (SCAN_US * (REF_HZ / 1000000));
    localparam int unsigned SCAN_W = 10;
    // reset values and the inverted address bit
    localparam logic [MON_W-1:0] MON_REF_RST = 8'h00;
    localparam logic [SEG_W-1:0] SEG_ZERO = 7'h3F;
    localparam int unsigned A13_BIT = 13;
endpackage

// *** rtl/ccs_sync2.sv ***
`timescale 1ns/1ns
module ccs_sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb
    begin
        meta_next = i_d;
        q_next = meta_reg;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_reg <= '0;
            o_q <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            o_q <= q_next;
        end
    end
endmodule

// *** rtl/ccs_card_logic.sv ***
`timescale 1ns/1ns
module ccs_card_logic (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    // oscillator enable and supply status
    input wire logic i_osc_en,
    input wire logic i_supply5_ok,
    input wire logic i_aux_reset_input_b,
    // outputs to processor side
    output logic o_cpu_clk,
    output logic o_cpu_clk_en,
    output logic o_nmi_tick,
    output logic o_rst_panel_b,
    output logic o_rst_gpib_b,
    output logic o_rst_cpu_b,
    output logic o_relay_zero,
    output logic o_gpib_remote,
    // remote control request
    input wire logic i_remote_set,
    // change monitor
    input wire logic [ccs_pkg::MON_W-1:0] i_mon_lines,
    input wire logic i_mon_get,
    input wire logic i_mon_put,
    input wire logic [ccs_pkg::MON_W-1:0] i_mon_wdata,
    output logic [ccs_pkg::MON_W-1:0] o_mon_rdata,
    output logic o_mon_irq,
    // test connector and address path
    input wire logic i_bus_hold_request_b,
    output logic o_bus_oe,
    input wire logic [15:0] i_cpu_addr,
    output logic [15:0] o_ram_addr,
    // decade buttons
    input wire logic [ccs_pkg::BTN_N-1:0] i_btn,
    input wire logic i_btn_ack,
    input wire logic i_ratio_ok,
    output logic o_btn_irq,
    output logic [ccs_pkg::BTN_IDX_W-1:0] o_btn_code,
    output logic o_btn_held,
    // display scan
    input wire logic i_disp_we,
    input wire logic [ccs_pkg::DIG_IDX_W-1:0] i_disp_idx,
    input wire logic [ccs_pkg::SEG_W-1:0] i_disp_seg,
    output logic [ccs_pkg::DIG_N-1:0] o_dig_pwr,
    output logic [ccs_pkg::SEG_W-1:0] o_seg
);
    //------------------------------------------------------------
    // input synchronisers
    //------------------------------------------------------------
    logic s_osc;
    logic s_sup5;
    logic s_aux_b;
    logic s_hold_b;
    logic [ccs_pkg::MON_W-1:0] s_mon;
    logic [ccs_pkg::BTN_N-1:0] s_btn;

    ccs_sync2 #(.W(4)) u_sync_ctl (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_d({i_osc_en, i_supply5_ok, i_aux_reset_input_b, i_bus_hold_request_b}),
        .o_q({s_osc, s_sup5, s_aux_b, s_hold_b})
    );
    ccs_sync2 #(.W(ccs_pkg::MON_W)) u_sync_mon (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_d(i_mon_lines),
        .o_q(s_mon)
    );
    ccs_sync2 #(.W(ccs_pkg::BTN_N)) u_sync_btn (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_d(i_btn),
        .o_q(s_btn)
    );

    //------------------------------------------------------------
    // power monitor
    //------------------------------------------------------------
    logic fail;
    logic rst_reg;
    logic rst_next;
    assign fail = !s_sup5 || !s_aux_b;
    always_comb
    begin
        rst_next = !fail;
    end
    assign o_rst_panel_b = rst_reg;
    assign o_rst_gpib_b = rst_reg;
    assign o_rst_cpu_b = rst_reg;
    logic sys_run;
    assign sys_run = rst_reg;

    //------------------------------------------------------------
    // clock divide by three and tick
    //------------------------------------------------------------
    logic [1:0] jk_reg;
    logic [1:0] jk_next;
    logic [ccs_pkg::TICK_W-1:0] tick_reg;
    logic [ccs_pkg::TICK_W-1:0] tick_next;
    logic nmi_reg;
    logic nmi_next;
    always_comb
    begin
        jk_next = jk_reg;
        tick_next = tick_reg;
        nmi_next = 1'b0;
        if (s_osc)
        begin
            // two-flop sequence 00 -> 01 -> 10 -> 00
            jk_next = {jk_reg[0], ~(jk_reg[0] | jk_reg[1])};
            if (jk_reg == 2'b10)
            begin
                tick_next = tick_reg + 1'b1;
                nmi_next = (tick_reg == ccs_pkg::TICK_W'(ccs_pkg::TICK_DIV - 1));
            end
        end
    end
    assign o_cpu_clk = jk_reg[0];
    assign o_cpu_clk_en = s_osc && (jk_reg == 2'b10);

    //------------------------------------------------------------
    // reset effects on relays and remote state
    //------------------------------------------------------------
    logic remote_reg;
    logic remote_next;
    always_comb
    begin
        remote_next = remote_reg;
        if (!sys_run)
            remote_next = 1'b0;
        else if (i_remote_set)
            remote_next = 1'b1;
    end
    assign o_gpib_remote = remote_reg;
    assign o_relay_zero = !sys_run;

    //------------------------------------------------------------
    // change monitor
    //------------------------------------------------------------
    logic [ccs_pkg::MON_W-1:0] mref_reg;
    logic [ccs_pkg::MON_W-1:0] mref_next;
    logic [ccs_pkg::MON_W-1:0] mout_reg;
    logic [ccs_pkg::MON_W-1:0] mout_next;
    always_comb
    begin
        mref_next = mref_reg;
        mout_next = mout_reg;
        if (i_mon_get)
            mout_next = s_mon;
        if (i_mon_put)
            mref_next = i_mon_wdata;
        if (!sys_run)
            mref_next = ccs_pkg::MON_REF_RST;
    end
    assign o_mon_rdata = mout_reg;
    assign o_mon_irq = (s_mon != mref_reg);

    //------------------------------------------------------------
    // bus hold and address path
    //------------------------------------------------------------
    assign o_bus_oe = s_hold_b;
    assign o_ram_addr = i_cpu_addr ^ (16'h0001 << ccs_pkg::A13_BIT);

    //------------------------------------------------------------
    // decade buttons
    //------------------------------------------------------------
    logic [ccs_pkg::BTN_N-1:0] bstab_reg;
    logic [ccs_pkg::BTN_N-1:0] bstab_next;
    logic [ccs_pkg::BTN_N-1:0] bsamp_reg;
    logic [ccs_pkg::BTN_N-1:0] bsamp_next;
    logic [ccs_pkg::DEB_W-1:0] deb_reg;
    logic [ccs_pkg::DEB_W-1:0] deb_next;
    logic birq_reg;
    logic birq_next;
    logic [ccs_pkg::BTN_IDX_W-1:0] bcode_reg;
    logic [ccs_pkg::BTN_IDX_W-1:0] bcode_next;
    logic press;
    logic [ccs_pkg::BTN_IDX_W-1:0] pidx;
    always_comb
    begin
        pidx = '0;
        // taken from the next stable set so the code is right in the press cycle
        for (int i = ccs_pkg::BTN_N - 1; i >= 0; i--)
            if (bstab_next[i])
                pidx = ccs_pkg::BTN_IDX_W'(i);
    end
    always_comb
    begin
        bsamp_next = s_btn;
        bstab_next = bstab_reg;
        deb_next = deb_reg;
        press = 1'b0;
        if (s_btn != bsamp_reg)
            deb_next = '0;
        else if (deb_reg != ccs_pkg::DEB_W'(ccs_pkg::DEB_CYC))
            deb_next = deb_reg + 1'b1;
        else
        begin
            bstab_next = bsamp_reg;
            press = (bsamp_reg & ~bstab_reg) != '0;
        end
        birq_next = birq_reg;
        bcode_next = bcode_reg;
        if (i_btn_ack)
            birq_next = 1'b0;
        if (press)
            birq_next = 1'b1;
        if (bstab_next != '0 && !birq_reg)
            bcode_next = pidx;
        if (!sys_run)
            birq_next = 1'b0;
    end
    assign o_btn_irq = birq_reg;
    assign o_btn_code = bcode_reg;
    assign o_btn_held = (bstab_reg != '0) && i_ratio_ok;

    //------------------------------------------------------------
    // display scan
    //------------------------------------------------------------
    logic [ccs_pkg::SEG_W-1:0] dmem_reg [ccs_pkg::DIG_N];
    logic [ccs_pkg::SEG_W-1:0] dmem_next [ccs_pkg::DIG_N];
    logic [ccs_pkg::SCAN_W-1:0] scnt_reg;
    logic [ccs_pkg::SCAN_W-1:0] scnt_next;
    logic [ccs_pkg::DIG_IDX_W-1:0] dsel_reg;
    logic [ccs_pkg::DIG_IDX_W-1:0] dsel_next;
    logic [ccs_pkg::SEG_W-1:0] seg_reg;
    logic [ccs_pkg::SEG_W-1:0] seg_next;
    logic [ccs_pkg::DIG_N-1:0] pwr_reg;
    logic [ccs_pkg::DIG_N-1:0] pwr_next;
    always_comb
    begin
        dmem_next = dmem_reg;
        scnt_next = scnt_reg + 1'b1;
        dsel_next = dsel_reg;
        if (i_disp_we && i_disp_idx < ccs_pkg::DIG_IDX_W'(ccs_pkg::DIG_N))
            dmem_next[i_disp_idx] = i_disp_seg;
        if (!sys_run)
            for (int i = 0; i < ccs_pkg::DIG_N; i++)
                dmem_next[i] = ccs_pkg::SEG_ZERO;
        if (scnt_reg == ccs_pkg::SCAN_W'(ccs_pkg::SCAN_CYC - 1))
        begin
            scnt_next = '0;
            dsel_next = (dsel_reg == ccs_pkg::DIG_IDX_W'(ccs_pkg::DIG_N - 1)) ? '0 : dsel_reg + 1'b1;
        end
        pwr_next = ccs_pkg::DIG_N'(1) << dsel_reg;
        seg_next = dmem_reg[dsel_reg];
    end
    assign o_dig_pwr = pwr_reg;
    assign o_seg = seg_reg;

    //------------------------------------------------------------
    // state registers
    //------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rst_reg <= 1'b0;
            jk_reg <= 2'b00;
            tick_reg <= '0;
            nmi_reg <= 1'b0;
            remote_reg <= 1'b0;
            mref_reg <= ccs_pkg::MON_REF_RST;
            mout_reg <= '0;
            bstab_reg <= '0;
            bsamp_reg <= '0;
            deb_reg <= '0;
            birq_reg <= 1'b0;
            bcode_reg <= '0;
            scnt_reg <= '0;
            dsel_reg <= '0;
            seg_reg <= '0;
            pwr_reg <= '0;
            for (int i = 0; i < ccs_pkg::DIG_N; i++)
                dmem_reg[i] <= ccs_pkg::SEG_ZERO;
        end
        else
        begin
            rst_reg <= rst_next;
            jk_reg <= jk_next;
            tick_reg <= tick_next;
            nmi_reg <= nmi_next;
            remote_reg <= remote_next;
            mref_reg <= mref_next;
            mout_reg <= mout_next;
            bstab_reg <= bstab_next;
            bsamp_reg <= bsamp_next;
            deb_reg <= deb_next;
            birq_reg <= birq_next;
            bcode_reg <= bcode_next;
            scnt_reg <= scnt_next;
            dsel_reg <= dsel_next;
            seg_reg <= seg_next;
            pwr_reg <= pwr_next;
            dmem_reg <= dmem_next;
        end
    end
    assign o_nmi_tick = nmi_reg;
endmodule

// *** tb/ccs_card_checker.sv ***
`timescale 1ns/1ns
module ccs_card_checker (
    // clock, reset and inputs
    input logic i_ref_clk,
    input logic i_rst_b,
    input logic i_supply5_ok,
    input logic i_aux_reset_input_b,
    input logic i_bus_hold_request_b,
    input logic i_mon_get,
    input logic i_mon_put,
    input logic [ccs_pkg::MON_W-1:0] i_mon_lines,
    input logic [ccs_pkg::MON_W-1:0] i_mon_wdata,
    input logic [15:0] i_cpu_addr,
    input logic [ccs_pkg::BTN_N-1:0] i_btn,
    // outputs watched
    input logic [ccs_pkg::MON_W-1:0] o_mon_rdata,
    input logic [15:0] o_ram_addr,
    input logic o_mon_irq,
    input logic o_cpu_clk_en,
    input logic o_rst_panel_b,
    input logic o_rst_gpib_b,
    input logic o_rst_cpu_b,
    input logic o_relay_zero,
    input logic o_bus_oe,
    input logic o_btn_irq
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_b);
    // reference as the processor last wrote it
    logic [ccs_pkg::MON_W-1:0] mref_shadow;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            mref_shadow <= ccs_pkg::MON_REF_RST;
        else if (!o_rst_cpu_b)
            mref_shadow <= ccs_pkg::MON_REF_RST;
        else if (i_mon_put)
            mref_shadow <= i_mon_wdata;
    end
    property p_fan; o_rst_panel_b == o_rst_cpu_b && o_rst_gpib_b == o_rst_cpu_b; endproperty
    a_fan: assert property (p_fan) else $error("reset outputs differ");
    property p_sup; (!i_supply5_ok)[*5] |-> !o_rst_cpu_b; endproperty
    a_sup: assert property (p_sup) else $error("no reset on supply fail");
    property p_aux; (!i_aux_reset_input_b)[*5] |-> !o_rst_cpu_b; endproperty
    a_aux: assert property (p_aux) else $error("no reset on aux fail");
    property p_relay; o_relay_zero == !o_rst_cpu_b; endproperty
    a_relay: assert property (p_relay) else $error("relay zero wrong");
    property p_set; $stable(i_mon_lines)[*3] |-> o_mon_irq == (i_mon_lines != mref_shadow); endproperty
    a_set: assert property (p_set) else $error("change irq missing");
    property p_get; $stable(i_mon_lines)[*3] ##0 (o_rst_cpu_b && i_mon_get) |=> o_mon_rdata == $past(i_mon_lines); endproperty
    a_get: assert property (p_get) else $error("latched lines wrong");
    property p_oe; (!i_bus_hold_request_b)[*5] |-> !o_bus_oe; endproperty
    a_oe: assert property (p_oe) else $error("buffers still drive");
    property p_addr; o_ram_addr == (i_cpu_addr ^ 16'h2000); endproperty
    a_addr: assert property (p_addr) else $error("ram address wrong");
    property p_en; o_cpu_clk_en |=> !o_cpu_clk_en; endproperty
    a_en: assert property (p_en) else $error("clock enable too close");
    property p_btn; $rose(o_btn_irq) |-> $past(i_btn, 60) != 0; endproperty
    a_btn: assert property (p_btn) else $error("button irq not debounced");
endmodule
bind ccs_card_logic ccs_card_checker i_ccs_card_checker (.*);

// *** tb/ccs_cpu_model.sv ***
`timescale 1ns/1ns
module ccs_cpu_model (
    // clock and pace
    input logic i_ref_clk,
    input logic i_slow,
    // from the block
    input logic i_mon_irq,
    input logic [ccs_pkg::MON_W-1:0] i_mon_rdata,
    input logic i_btn_irq,
    input logic [ccs_pkg::BTN_IDX_W-1:0] i_btn_code,
    // to the block and the bench
    output logic o_get = '0,
    output logic o_put = '0,
    output logic [ccs_pkg::MON_W-1:0] o_wdata = '0,
    output logic o_ack = '0,
    output logic [ccs_pkg::MON_W-1:0] o_ref = '0,
    output logic [ccs_pkg::BTN_IDX_W-1:0] o_code = '0,
    output int o_n_mon = 0,
    output int o_n_btn = 0
);
    int st = 0;
    int wt = 0;
    always @(posedge i_ref_clk)
    begin
        o_get <= '0;
        o_put <= '0;
        o_wdata <= ~o_wdata;
        o_ack <= i_btn_irq && !o_ack;
        if (i_btn_irq && !o_ack)
        begin
            o_code <= i_btn_code;
            o_n_btn <= o_n_btn + 1;
        end
        case (st)
            0:
            begin
                wt <= i_mon_irq ? wt + 1 : 0;
                if (i_mon_irq && wt >= (i_slow ? 20 : 0))
                begin
                    o_get <= '1;
                    wt <= 0;
                    st <= 1;
                end
            end
            2:
            begin
                o_put <= '1;
                o_wdata <= i_mon_rdata;
                st <= 3;
            end
            3:
            begin
                o_ref <= o_wdata;
                o_n_mon <= o_n_mon + 1;
                st <= 4;
            end
            default: st <= (st == 4) ? 0 : st + 1;
        endcase
    end
endmodule

// *** tb/ccs_card_logic_tb.sv ***
`timescale 1ns/1ns
module ccs_card_logic_tb;
    logic i_ref_clk = '0;
    logic i_rst_b = '0;
    logic i_osc_en = '1;
    logic i_supply5_ok = '1;
    logic i_aux_reset_input_b = '1;
    logic i_remote_set = '0;
    logic i_bus_hold_request_b = '1;
    logic i_ratio_ok = '0;
    logic i_disp_we = '0;
    logic slow = '0;
    logic [7:0] i_mon_lines = '0;
    logic [15:0] i_cpu_addr = '0;
    logic [15:0] i_btn = '0;
    logic [3:0] i_disp_idx = '0;
    logic [6:0] i_disp_seg = '0;
    logic o_cpu_clk, o_cpu_clk_en, o_nmi_tick, o_rst_panel_b, o_rst_gpib_b, o_rst_cpu_b, o_relay_zero;
    logic o_gpib_remote, o_mon_irq, o_bus_oe, o_btn_irq, o_btn_held, i_mon_get, i_mon_put, i_btn_ack;
    logic [7:0] o_mon_rdata, i_mon_wdata, mref;
    logic [7:0] q[$];
    logic [15:0] o_ram_addr;
    logic [3:0] o_btn_code, code;
    logic [11:0] o_dig_pwr;
    logic [6:0] o_seg;
    int n_mon, n_btn, k, c, e, h, v, d;
    int err_total = 0;
    int total_checks = 0;
    int seed = 32'haa58;
    ccs_cpu_model i_ccs_cpu_model (
        .i_ref_clk(i_ref_clk),
        .i_slow(slow),
        .i_mon_irq(o_mon_irq),
        .i_mon_rdata(o_mon_rdata),
        .i_btn_irq(o_btn_irq),
        .i_btn_code(o_btn_code),
        .o_get(i_mon_get),
        .o_put(i_mon_put),
        .o_wdata(i_mon_wdata),
        .o_ack(i_btn_ack),
        .o_ref(mref),
        .o_code(code),
        .o_n_mon(n_mon),
        .o_n_btn(n_btn)
    );
    ccs_card_logic i_ccs_card_logic (.*);
    initial
    begin
        forever #50 i_ref_clk = ~i_ref_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic to(input logic ok);
        if (ok !== 1'h1)
        begin
            err_total++;
            $display("unexpected at %0t: wait expired", $time);
            report_and_stop();
        end
    endtask
    initial
    begin
        cyc(3);
        chk(16'({o_rst_panel_b, o_rst_gpib_b, o_rst_cpu_b, o_relay_zero, o_gpib_remote}), 16'h0002);
        @(posedge i_ref_clk) i_rst_b <= '1;
        cyc(10);
        chk(o_seg, ccs_pkg::SEG_ZERO);
        for (k = 0; k < 2; k++)
        begin
            @(posedge i_ref_clk) i_remote_set <= '1;
            @(posedge i_ref_clk) i_remote_set <= '0;
            cyc(4);
            chk(o_gpib_remote, 1);
            @(posedge i_ref_clk) {i_aux_reset_input_b, i_supply5_ok} <= 2'(1 << k);
            cyc(20);
            chk(16'({o_rst_panel_b, o_rst_gpib_b, o_rst_cpu_b, o_relay_zero, o_gpib_remote}), 16'h0002);
            @(posedge i_ref_clk) {i_aux_reset_input_b, i_supply5_ok} <= '1;
            cyc(10);
            chk(o_rst_cpu_b, 1);
        end
        repeat (8)
        begin
            @(posedge i_ref_clk) i_cpu_addr <= 16'($random(seed));
            cyc(0);
            chk(o_ram_addr, i_cpu_addr ^ 16'h2000);
        end
        for (k = 0; k < 6; k++)
        begin
            v = 32'(i_mon_lines ^ (8'($random(seed)) | 8'h01));
            c = n_mon;
            q.push_back(8'(v));
            @(posedge i_ref_clk) slow <= k[0];
            i_mon_lines <= 8'(v);
            cyc(8);
            if (k[0])
                chk(o_mon_irq, 1);
            for (e = 0; e < 60 && n_mon == c; e++) cyc(0);
            to(n_mon != c);
            cyc(3);
            chk(mref, q.pop_front());
            chk(o_mon_irq, 0);
        end
        for (k = 0; k < 13000 && o_nmi_tick !== 1'h1; k++) cyc(0);
        to(o_nmi_tick);
        c = 0;
        e = 0;
        h = 0;
        do
        begin
            cyc(0);
            c++;
            e += o_cpu_clk_en;
            h += o_cpu_clk;
        end while (o_nmi_tick !== 1'h1 && c < 13000);
        chk(c, 3 * 4096);
        chk(e, 4096);
        chk(h, 4096);
        @(posedge i_ref_clk) i_osc_en <= '0;
        cyc(4);
        e = 0;
        repeat (9)
        begin
            cyc(0);
            e += o_cpu_clk_en;
        end
        chk(e, 0);
        @(posedge i_ref_clk) i_osc_en <= '1;
        for (k = 0; k < 2; k++)
        begin
            @(posedge i_ref_clk) i_bus_hold_request_b <= k[0];
            cyc(6);
            chk(o_bus_oe, k[0]);
        end
        for (k = 0; k < 5; k++)
        begin
            d = $unsigned($random(seed)) % 15;
            c = n_btn;
            @(posedge i_ref_clk) i_btn <= 16'(1 << d) | 16'h8000;
            i_ratio_ok <= k[0];
            for (e = 0; e < 300 && n_btn == c; e++) cyc(0);
            to(n_btn != c);
            chk(code, d);
            cyc(5);
            chk(o_btn_held, k[0]);
            @(posedge i_ref_clk) i_btn <= '0;
            cyc(150);
        end
        d = $unsigned($random(seed)) % 12;
        v = 32'(7'($random(seed)));
        @(posedge i_ref_clk) i_disp_we <= '1;
        i_disp_idx <= 4'(d);
        i_disp_seg <= 7'(v);
        @(posedge i_ref_clk) i_disp_we <= '0;
        cyc(1);
        for (k = 0; k < 2; k++)
        begin
            for (e = 0; e < 13000 && o_dig_pwr !== 12'(1 << ((d + k) % 12)); e++) cyc(0);
            to(e < 13000);
            chk(o_seg, k ? 16'(ccs_pkg::SEG_ZERO) : 16'(v));
        end
        report_and_stop();
    end
endmodule
